// ---- shared/vic_regs.svh ----
// Register addresses, command codes, field positions and reset values of the vectored interrupt controller
`ifndef VIC_REGS_SVH
`define VIC_REGS_SVH
// ==========================================================================
// Board byte addresses of the two host ports
`define VIC_DATA_PORT_ADDR 24'hef00c0
`define VIC_CTRL_PORT_ADDR 24'hef00d0
// ==========================================================================
// Command opcodes, command bits 7:4
`define VIC_OP_RESET 4'h0
`define VIC_OP_CLR_ISR 4'h1
`define VIC_OP_SET_IRR 4'h2
`define VIC_OP_CLR_IRR 4'h3
`define VIC_OP_CLR_MASK 4'h4
`define VIC_OP_SET_MASK 4'h5
`define VIC_OP_LOAD_MASK 4'h6
`define VIC_OP_LOAD_ACLR 4'h7
`define VIC_OP_MODE_LO0 4'h8
`define VIC_OP_MODE_LO1 4'h9
`define VIC_OP_PRESEL 4'ha
`define VIC_OP_MODE7 4'hb
`define VIC_OP_RESP0 4'hc
`define VIC_OP_RESP1 4'hd
// Command fields
`define VIC_CMD_ALL 3
`define VIC_CMD_MODE_LO 4:0
`define VIC_CMD_COUNT 4:3
// ==========================================================================
// Mode bits
`define VIC_MODE_ROTATE 0
`define VIC_MODE_COMMON 1
`define VIC_MODE_POLLED 2
`define VIC_MODE_GPOL 3
`define VIC_MODE_RPOL 4
`define VIC_MODE_PRESEL 6:5
`define VIC_MODE_ARM 7
// Data port preselect codes
`define VIC_SEL_IRR 2'h0
`define VIC_SEL_ISR 2'h1
`define VIC_SEL_MASK 2'h2
`define VIC_SEL_ACLR 2'h3
// ==========================================================================
// Reset values
`define VIC_RST_ZERO 8'h00
`define VIC_RST_MASK 8'hff
`define VIC_RST_CMD 8'h00
`endif

// ---- shared/vic_pkg.sv ----
// Types shared by the vectored interrupt controller
package vic_pkg;
  // Host pins as seen by the controller
  typedef struct packed {
    logic cs_n;
    logic cd;
    logic rd_n;
    logic wr_n;
    logic irq_acknowledge_in_n;
    logic [7:0] data;
  } vic_bus_in_t;
  // Acknowledge sequencer states
  typedef enum logic [1:0] {
    VIC_ST_IDLE,
    VIC_ST_SEL,
    VIC_ST_RESP
  } vic_state_t;
  // Status register layout, bit 7 down to 0
  typedef struct packed {
    logic group_irq;
    logic arm;
    logic polled;
    logic rotate;
    logic any_pending;
    logic [2:0] pending_level_status_bits;
  } vic_status_t;
endpackage

// ---- logic/vic_core.sv ----
// Eight-input vectored interrupt controller with response memory
`timescale 1ns/10ps
`include "vic_regs.svh"
//
// Overview of operation
// - Eight-bit pending register, a bit set when its request input becomes active.
// - Host commands set pending bits (software interrupts) and clear them.
// - Acknowledge clears the pending bit and sets the matching in-service bit.
// - Reset clears pending, in-service and auto-clear bits and sets all mask bits.
// - A set in-service bit blocks all lower priority interrupts until cleared.
// - Auto-clear on: in-service bit cleared at end of acknowledge; off: by command.
// - All mask bits loaded, set or cleared together; single bits set or cleared.
// - Masked requests still latch and interrupt once unmasked.
// - Group interrupt raised only by unmasked pending requests.
// - Writable response memory of eight entries by 32 bits.
// - During acknowledge, drive response bytes of the highest priority unmasked request, or of entry 0 when mode bit 1 is set.
// - Status bit 7 shows group interrupt with fixed polarity, ignoring mode bit 3.
// - Read with chip select on the control location returns status.
// - Mode bits 0 to 4 load by one command; bits 5, 6, 7 by their own.
// - Mode not readable; mode bits 0, 2, 7 appear in status.
// - Control writes load the command register, starting actions or preparing data writes.
// - Two-bit byte count per request; response-in-progress low until count met.
// - Eight maskable inputs, priority resolved, up to four response bytes each.
// - Channels 0 to 7 carry the eight board sources, levels 3.7 down to 3.0.
// - Acknowledge drops pause, selects winner, then drops response-in-progress with byte one.
// - Fixed priority: input 0 highest, input 7 lowest.
// - After in-service set, group output off until higher request or bit cleared.
// - Data reads return register preselected by mode bits 5, 6; memory via acknowledge only.
module vic_core #(
  parameter int NUM_REQ = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire vic_pkg::vic_bus_in_t i_bus,
  input wire logic [NUM_REQ-1:0] i_irq_request_in,
  output logic [7:0] o_data,
  output logic o_data_oe,
  output logic o_group_irq_out,
  output logic o_pause_n,
  output logic o_response_in_progress_out_n
);
  import vic_pkg::*;

  // ========================================================================
  // Parameter check
  // eight maskable inputs only
  generate
    if (NUM_REQ != 8) begin : g_bad_num
      $error("vic_core supports exactly eight request inputs");
    end
  endgenerate

  // ========================================================================
  // Pin synchronisers
  vic_bus_in_t bus_meta_reg;
  vic_bus_in_t bus_sync_reg;
  vic_bus_in_t bus_prev_reg;
  logic [NUM_REQ-1:0] req_meta_reg;
  logic [NUM_REQ-1:0] req_sync_reg;
  logic [NUM_REQ-1:0] req_prev_reg;

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      bus_meta_reg <= '1;
      bus_sync_reg <= '1;
      bus_prev_reg <= '1;
      req_meta_reg <= '0;
      req_sync_reg <= '0;
      req_prev_reg <= '0;
    end else begin
      bus_meta_reg <= i_bus;
      bus_sync_reg <= bus_meta_reg;
      bus_prev_reg <= bus_sync_reg;
      req_meta_reg <= i_irq_request_in;
      req_sync_reg <= req_meta_reg;
      req_prev_reg <= req_sync_reg;
    end
  end

  // ========================================================================
  // Registers and strobes
  logic [7:0] pending_request_reg;
  logic [7:0] in_service_reg;
  logic [7:0] request_mask_reg;
  logic [7:0] auto_clear_reg;
  logic [7:0] operating_options_reg;
  logic [7:0] last_command_reg;
  logic [1:0] response_length_reg [NUM_REQ];
  logic [31:0] resp_mem [NUM_REQ];
  logic [2:0] load_level_reg;
  logic [1:0] load_byte_reg;
  vic_state_t state_reg;
  logic [2:0] sel_reg;
  logic [1:0] byte_reg;
  logic [7:0] data_reg;
  logic oe_reg;
  logic group_irq_out_reg;

  logic sel_cs;
  logic wr_end;
  logic cmd_wr;
  logic data_wr;
  logic ack_fall;
  logic ack_rise;
  logic [3:0] opcode;
  logic [7:0] cmd_bit;
  logic [7:0] req_edge;
  logic [7:0] allowed;
  logic [7:0] eligible;
  logic [2:0] winner;
  logic group_irq_out_active;
  logic ack_take;
  logic ack_done;
  logic reset_cmd;
  vic_status_t status;

  assign sel_cs = ~bus_sync_reg.cs_n;
  // Act at the trailing edge of write so data has settled through the sync
  assign wr_end = bus_sync_reg.wr_n & ~bus_prev_reg.wr_n & sel_cs;
  assign cmd_wr = wr_end & bus_sync_reg.cd;
  assign data_wr = wr_end & ~bus_sync_reg.cd;
  assign ack_fall = ~bus_sync_reg.irq_acknowledge_in_n & bus_prev_reg.irq_acknowledge_in_n & bus_sync_reg.cs_n;
  assign ack_rise = bus_sync_reg.irq_acknowledge_in_n & ~bus_prev_reg.irq_acknowledge_in_n;
  assign opcode = bus_sync_reg.data[7:4];
  assign reset_cmd = cmd_wr & (opcode == `VIC_OP_RESET);
  assign cmd_bit = bus_sync_reg.data[`VIC_CMD_ALL] ? 8'hff : (8'h01 << bus_sync_reg.data[2:0]);

  // ========================================================================
  // Per-channel request edge and priority blocking
  // channel index equals board source order
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REQ; gi++) begin : g_chan
      // latch on the request becoming active, polarity from mode bit 4
      assign req_edge[gi] = operating_options_reg[`VIC_MODE_RPOL] ? (req_sync_reg[gi] & ~req_prev_reg[gi])
                                                                 : (~req_sync_reg[gi] & req_prev_reg[gi]);
      // any in-service bit at equal or higher priority blocks this one
      assign allowed[gi] = ~|in_service_reg[gi:0];
    end
  endgenerate

  assign eligible = pending_request_reg & ~request_mask_reg & allowed;

  always_comb begin
    winner = 3'h0;
    for (int i = NUM_REQ - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        winner = 3'(i);
      end
    end
  end

  // group interrupt disabled in polled mode or when not armed
  assign group_irq_out_active = |eligible & ~operating_options_reg[`VIC_MODE_POLLED] & operating_options_reg[`VIC_MODE_ARM];
  assign ack_take = (state_reg == VIC_ST_SEL) & |eligible;
  assign ack_done = (state_reg == VIC_ST_RESP) & ack_rise & (byte_reg == response_length_reg[sel_reg]);

  // ========================================================================
  // Pending register; hardware set wins over a clear in the same cycle
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      pending_request_reg <= `VIC_RST_ZERO;
    end else begin
      // reset command clears all pending bits except those set by a request edge in the same cycle
      if (reset_cmd) begin
        pending_request_reg <= req_edge;
      end else begin
        pending_request_reg <= (pending_request_reg
                                & ~((cmd_wr && opcode == `VIC_OP_CLR_IRR) ? cmd_bit : 8'h00)
                                // acknowledge clears the selected pending bit
                                & ~(ack_take ? (8'h01 << winner) : 8'h00))
                               | ((cmd_wr && opcode == `VIC_OP_SET_IRR) ? cmd_bit : 8'h00)
                               | req_edge;
      end
    end
  end

  // In-service register
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      in_service_reg <= `VIC_RST_ZERO;
    end else if (reset_cmd) begin
      in_service_reg <= `VIC_RST_ZERO;
    end else begin
      // set on acknowledge; auto-clear at end of sequence
      in_service_reg <= (in_service_reg
                         & ~((cmd_wr && opcode == `VIC_OP_CLR_ISR) ? cmd_bit : 8'h00)
                         & ~((ack_done && auto_clear_reg[sel_reg]) ? (8'h01 << sel_reg) : 8'h00))
                        | (ack_take ? (8'h01 << winner) : 8'h00);
    end
  end

  // Mask register
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      request_mask_reg <= `VIC_RST_MASK;
    end else if (reset_cmd) begin
      request_mask_reg <= `VIC_RST_MASK;
    end else if (cmd_wr && opcode == `VIC_OP_CLR_MASK) begin
      request_mask_reg <= request_mask_reg & ~cmd_bit;
    end else if (cmd_wr && opcode == `VIC_OP_SET_MASK) begin
      request_mask_reg <= request_mask_reg | cmd_bit;
    end else if (data_wr && last_command_reg[7:4] == `VIC_OP_LOAD_MASK) begin
      request_mask_reg <= bus_sync_reg.data;
    end
  end

  // Auto-clear register
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      auto_clear_reg <= `VIC_RST_ZERO;
    end else if (reset_cmd) begin
      auto_clear_reg <= `VIC_RST_ZERO;
    end else if (data_wr && last_command_reg[7:4] == `VIC_OP_LOAD_ACLR) begin
      auto_clear_reg <= bus_sync_reg.data;
    end
  end

  // Mode and command registers
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      operating_options_reg <= `VIC_RST_ZERO;
      last_command_reg <= `VIC_RST_CMD;
    end else if (cmd_wr) begin
      last_command_reg <= bus_sync_reg.data;
      // low mode bits in parallel, bits 5 to 7 separately
      unique case (opcode)
        `VIC_OP_RESET: operating_options_reg <= `VIC_RST_ZERO;
        `VIC_OP_MODE_LO0, `VIC_OP_MODE_LO1: operating_options_reg[4:0] <= bus_sync_reg.data[`VIC_CMD_MODE_LO];
        `VIC_OP_PRESEL: operating_options_reg[`VIC_MODE_PRESEL] <= bus_sync_reg.data[1:0];
        `VIC_OP_MODE7: operating_options_reg[`VIC_MODE_ARM] <= bus_sync_reg.data[0];
        default: operating_options_reg <= operating_options_reg;
      endcase
    end
  end

  // ========================================================================
  // Response memory and byte counts; not touched by reset
  logic resp_cmd;
  assign resp_cmd = cmd_wr & (opcode == `VIC_OP_RESP0 || opcode == `VIC_OP_RESP1);

  // response memory written byte by byte after a preselect
  always_ff @(posedge i_clk_sys) begin
    if (resp_cmd) begin
      // byte count loaded with the level preselect
      response_length_reg[bus_sync_reg.data[2:0]] <= bus_sync_reg.data[`VIC_CMD_COUNT];
    end
    if (data_wr && (last_command_reg[7:4] == `VIC_OP_RESP0 || last_command_reg[7:4] == `VIC_OP_RESP1)) begin
      resp_mem[load_level_reg][8*load_byte_reg +: 8] <= bus_sync_reg.data;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      load_level_reg <= 3'h0;
      load_byte_reg <= 2'h0;
    end else if (resp_cmd) begin
      load_level_reg <= bus_sync_reg.data[2:0];
      load_byte_reg <= 2'h0;
    end else if (data_wr) begin
      load_byte_reg <= load_byte_reg + 2'h1;
    end
  end

  // ========================================================================
  // Acknowledge sequencer
  // pause, select, then response in progress
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      state_reg <= VIC_ST_IDLE;
      sel_reg <= 3'h0;
      byte_reg <= 2'h0;
    end else begin
      unique case (state_reg)
        VIC_ST_IDLE: begin
          if (ack_fall) begin
            state_reg <= VIC_ST_SEL;
          end
        end
        VIC_ST_SEL: begin
          sel_reg <= winner;
          byte_reg <= 2'h0;
          state_reg <= |eligible ? VIC_ST_RESP : VIC_ST_IDLE;
        end
        VIC_ST_RESP: begin
          // one acknowledge pulse per byte until the count is met
          if (ack_done) begin
            state_reg <= VIC_ST_IDLE;
          end else if (ack_rise) begin
            byte_reg <= byte_reg + 2'h1;
          end
        end
      endcase
    end
  end

  assign o_pause_n = ~(state_reg == VIC_ST_SEL);
  assign o_response_in_progress_out_n = ~(state_reg == VIC_ST_RESP);

  // ========================================================================
  // Status and data bus
  // fixed polarity group bit, mode bits 0, 2, 7
  assign status = '{group_irq: group_irq_out_active,
                    arm: operating_options_reg[`VIC_MODE_ARM],
                    polled: operating_options_reg[`VIC_MODE_POLLED],
                    rotate: operating_options_reg[`VIC_MODE_ROTATE],
                    any_pending: |eligible,
                    pending_level_status_bits: winner};

  logic [2:0] vec_level;
  logic [7:0] preselect_data;
  assign vec_level = operating_options_reg[`VIC_MODE_COMMON] ? 3'h0 : sel_reg;

  // data location reads follow the preselect
  always_comb begin
    unique case (operating_options_reg[`VIC_MODE_PRESEL])
      `VIC_SEL_IRR: preselect_data = pending_request_reg;
      `VIC_SEL_ISR: preselect_data = in_service_reg;
      `VIC_SEL_MASK: preselect_data = request_mask_reg;
      `VIC_SEL_ACLR: preselect_data = auto_clear_reg;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      data_reg <= 8'h00;
      oe_reg <= 1'b0;
    end else if (state_reg == VIC_ST_RESP && !bus_sync_reg.irq_acknowledge_in_n) begin
      // response byte of the selected request, or of entry 0 when mode bit 1 is set
      data_reg <= resp_mem[vec_level][8*byte_reg +: 8];
      oe_reg <= 1'b1;
    end else if (sel_cs && !bus_sync_reg.rd_n) begin
      data_reg <= bus_sync_reg.cd ? status : preselect_data;
      oe_reg <= 1'b1;
    end else begin
      data_reg <= 8'h00;
      oe_reg <= 1'b0;
    end
  end

  // Group output polarity from mode bit 3; 1 means active high
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      group_irq_out_reg <= 1'b1;
    end else begin
      group_irq_out_reg <= operating_options_reg[`VIC_MODE_GPOL] ? group_irq_out_active : ~group_irq_out_active;
    end
  end

  assign o_data = data_reg;
  assign o_data_oe = oe_reg;
  assign o_group_irq_out = group_irq_out_reg;

  // ========================================================================
  // Checks
  mask_reset_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    reset_cmd |=> request_mask_reg == `VIC_RST_MASK && in_service_reg == `VIC_RST_ZERO && auto_clear_reg == 8'h00)
    else $error("reset command did not restore registers");
  ack_move_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    ack_take |=> in_service_reg[sel_reg] && state_reg == VIC_ST_RESP)
    else $error("acknowledge did not set in-service bit");
  req_latch_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    req_edge != 8'h00 |=> (pending_request_reg & $past(req_edge)) == $past(req_edge))
    else $error("request edge not latched");
  group_irq_out_cause_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    group_irq_out_active |-> |(pending_request_reg & ~request_mask_reg))
    else $error("group interrupt without unmasked request");
  isr_block_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    in_service_reg[0] |-> !group_irq_out_active)
    else $error("top in-service bit failed to block");
  auto_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    ack_done && auto_clear_reg[sel_reg] |=> !in_service_reg[$past(sel_reg)])
    else $error("auto-clear did not clear in-service bit");
  pause_rip_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    ack_fall && state_reg == VIC_ST_IDLE |=> !o_pause_n ##1 (o_pause_n && (o_response_in_progress_out_n != $past(|eligible))))
    else $error("pause and response order wrong");
  status_bit_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    sel_cs && bus_sync_reg.cd && !bus_sync_reg.rd_n && state_reg != VIC_ST_RESP |=> o_data_oe && o_data[7] == $past(group_irq_out_active))
    else $error("status read wrong");
  mode_low_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    cmd_wr && opcode == `VIC_OP_MODE_LO0 |=> operating_options_reg[4:0] == $past(bus_sync_reg.data[4:0]))
    else $error("mode bits 0 to 4 not loaded");
  win_prio_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    eligible[0] |-> winner == 3'h0)
    else $error("input 0 not highest priority");
  cov_ack_c: cover property (@(posedge i_clk_sys) disable iff (i_reset) ack_take ##[1:200] ack_done);
  cov_nest_c: cover property (@(posedge i_clk_sys) disable iff (i_reset) ack_take && in_service_reg != 8'h00);
  cov_sw_c: cover property (@(posedge i_clk_sys) disable iff (i_reset) cmd_wr && opcode == `VIC_OP_SET_IRR);
endmodule

// ---- verification/vic_host_model.sv ----
// Behavioural host processor model for the controller bus pins
`timescale 1ns/10ps
module vic_host_model (
  input wire logic i_clk_sys,
  input wire logic [7:0] i_data,
  input wire logic i_data_oe,
  input wire logic i_rip_n,
  output vic_pkg::vic_bus_in_t o_bus
);
  import vic_pkg::*;
  initial begin
    o_bus = '{cs_n: 1'b1, cd: 1'b1, rd_n: 1'b1, wr_n: 1'b1, irq_acknowledge_in_n: 1'b1, data: 8'h5a};
  end
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  // ==========================================================================
  // Register cycles
  // Strobes stay long past the two-stage input sync; released data is inverted
  task automatic wr(input logic cd, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_bus.cs_n <= 1'b0;
    o_bus.cd <= cd;
    o_bus.data <= d;
    o_bus.wr_n <= 1'b0;
    idle(4);
    o_bus.wr_n <= 1'b1;
    idle(4);
    o_bus.cs_n <= 1'b1;
    o_bus.data <= ~d;
    idle(3);
  endtask
  task automatic rd(input logic cd, output logic [7:0] d);
    @(posedge i_clk_sys);
    o_bus.cs_n <= 1'b0;
    o_bus.cd <= cd;
    o_bus.rd_n <= 1'b0;
    idle(6);
    @(negedge i_clk_sys);
    d = i_data;
    @(posedge i_clk_sys);
    o_bus.rd_n <= 1'b1;
    o_bus.cs_n <= 1'b1;
    idle(5);
  endtask
  // ==========================================================================
  // Acknowledge pulse, chip select kept high
  task automatic ack(output logic [7:0] d, output logic [2:0] flags);
    @(posedge i_clk_sys);
    o_bus.irq_acknowledge_in_n <= 1'b0;
    idle(7);
    @(negedge i_clk_sys);
    d = i_data;
    flags[2] = i_data_oe;
    flags[1] = i_rip_n;
    @(posedge i_clk_sys);
    o_bus.irq_acknowledge_in_n <= 1'b1;
    idle(5);
    @(negedge i_clk_sys);
    flags[0] = i_rip_n;
  endtask
endmodule

// ---- verification/vic_core_tb_top.sv ----
// Self-checking testbench for the vectored interrupt controller
`timescale 1ns/10ps
module vic_core_tb_top;
  import vic_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic [7:0] i_irq_request_in = 8'hff;
  vic_bus_in_t bus;
  logic [7:0] o_data;
  logic o_data_oe;
  logic o_group_irq_out;
  logic o_pause_n;
  logic o_rip_n;
  logic [7:0] rv;
  logic [2:0] fl;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int pause_lows = 0;
  always #10 i_clk_sys = ~i_clk_sys;
  // Pause is a one-cycle pulse on the first acknowledge of each sequence, including one that finds no eligible request
  always @(negedge i_clk_sys) begin
    if (o_pause_n === 1'b0) begin
      pause_lows++;
    end
  end
  vic_core vic_core_i (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_bus(bus),
    .i_irq_request_in(i_irq_request_in), .o_data(o_data), .o_data_oe(o_data_oe),
    .o_group_irq_out(o_group_irq_out), .o_pause_n(o_pause_n), .o_response_in_progress_out_n(o_rip_n));
  vic_host_model vic_host_model_i (.i_clk_sys(i_clk_sys), .i_data(o_data), .i_data_oe(o_data_oe),
    .i_rip_n(o_rip_n), .o_bus(bus));
  // ==========================================================================
  // Helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    vic_host_model_i.wr(1'b1, c);
  endtask
  task automatic dwr(input logic [7:0] d);
    vic_host_model_i.wr(1'b0, d);
  endtask
  task automatic rdchk(input logic cd, input logic [7:0] exp);
    vic_host_model_i.rd(cd, rv);
    chk(rv, exp);
  endtask
  // Group output is active low on this board
  task automatic gchk(input logic [7:0] exp);
    @(negedge i_clk_sys);
    chk(8'(o_group_irq_out), exp);
  endtask
  task automatic req_pulse(input int k);
    @(posedge i_clk_sys);
    i_irq_request_in[k] <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    i_irq_request_in[k] <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Whole run needs about 790 cycles
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures++;
      print_verdict();
    end
  end
  // ==========================================================================
  // Test sequence
  initial begin
    repeat (10) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    rdchk(1'b0, 8'h00);
    cmd(8'ha2);
    rdchk(1'b0, 8'hff);
    cmd(8'ha3);
    rdchk(1'b0, 8'h00);
    rdchk(1'b1, 8'h00);
    cmd(8'hb1);
    cmd(8'h85);
    rdchk(1'b1, 8'h70);
    cmd(8'h80);
    rdchk(1'b1, 8'h40);
    for (int k = 0; k < 8; k++) begin
      cmd(8'hc0 | 8'(k));
      dwr(8'h40 + 8'(k));
    end
    cmd(8'ha0);
    req_pulse(2);
    rdchk(1'b0, 8'h04);
    gchk(8'h01);
    cmd(8'h48);
    gchk(8'h00);
    rdchk(1'b1, 8'hca);
    cmd(8'h20);
    rdchk(1'b1, 8'hc8);
    rdchk(1'b1, 8'hc8);
    vic_host_model_i.ack(rv, fl);
    chk(rv, 8'h40);
    chk(8'(fl), 8'h05);
    rdchk(1'b0, 8'h04);
    cmd(8'ha1);
    rdchk(1'b0, 8'h01);
    gchk(8'h01);
    cmd(8'h10);
    gchk(8'h00);
    cmd(8'h70);
    dwr(8'h04);
    vic_host_model_i.ack(rv, fl);
    chk(rv, 8'h42);
    rdchk(1'b0, 8'h00);
    gchk(8'h01);
    cmd(8'h23);
    gchk(8'h00);
    cmd(8'h53);
    gchk(8'h01);
    cmd(8'h60);
    dwr(8'h00);
    gchk(8'h00);
    cmd(8'h00);
    gchk(8'h01);
    rdchk(1'b0, 8'h00);
    cmd(8'h80);
    cmd(8'hb1);
    cmd(8'h60);
    dwr(8'h00);
    cmd(8'hcb);
    dwr(8'h11);
    dwr(8'h22);
    cmd(8'h23);
    vic_host_model_i.ack(rv, fl);
    chk(rv, 8'h11);
    chk(8'(fl), 8'h04);
    vic_host_model_i.ack(rv, fl);
    chk(rv, 8'h22);
    chk(8'(fl), 8'h05);
    cmd(8'h13);
    vic_host_model_i.ack(rv, fl);
    chk(8'(fl), 8'h03);
    chk(8'(pause_lows), 8'h04);
    print_verdict();
  end
endmodule
